// ### core/dpsf_status.sv
//------------------------------------------------------------------------
//------------------------------------------------------------------------
`timescale 1ns/100ps

module dpsf_status
  import dpsf_pkg::*;
#(
  parameter int unsigned JTAG_VARIANT = 0,
  parameter int unsigned PORT_VERSION = 1,
  parameter int unsigned HAS_COMPARE = 1
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic link_clk,
  input wire logic req_valid,
  input wire logic req_apndp,
  input wire logic req_rnw,
  input wire logic [3:0] req_addr,
  input wire logic [3:0] req_bank,
  input wire logic [31:0] req_wdata,
  input wire logic ap_resp_valid,
  input wire logic ap_resp_ok,
  input wire logic ap_resp_read,
  input wire logic [31:0] ap_resp_rdata,
  input wire logic overrun_event,
  output logic [31:0] rdata_q,
  output logic rdata_valid_q,
  output logic ap_req_valid_q,
  output logic ap_req_rnw_q,
  output logic [3:0] ap_req_addr_q,
  output logic [31:0] ap_req_wdata_q
);

  // ------------------------------------------------------------------
  // Elaboration checks
  // ------------------------------------------------------------------
  if (JTAG_VARIANT > 1 || PORT_VERSION > 2 || HAS_COMPARE > 1) begin : g_bad_param
    $error("dpsf_status: unsupported variant, version or compare option");
  end

  // Flags are read-only (abort cleared) except on the first scan version
  localparam bit RO_FLAGS = (JTAG_VARIANT == 0) || (PORT_VERSION >= 1);
  localparam bit HAS_RDOK = (JTAG_VARIANT == 0) && (PORT_VERSION >= 1);

  // ------------------------------------------------------------------
  // Link clock sampling and request decode
  // ------------------------------------------------------------------
  logic link_rise;

  dpsf_sync3 u_link_sync (
    .clk(clk),
    .sys_rst(sys_rst),
    .async_in(link_clk),
    .level_o(),
    .rise_o(link_rise)
  );

  // Request pins are held a whole link period, so they are steady
  // long before the synchronised edge reaches this point
  logic take;
  logic ctrl_hit;
  logic data_link_control_hit;
  logic abort_wr;
  logic ctrl_wr;
  logic data_link_control_wr;
  logic ap_take;

  // Low two address bits never take part in decode
  function automatic logic addr_is(input logic [3:0] a, input logic [3:0] ref_a);
    addr_is = (a[3:2] == ref_a[3:2]);
  endfunction : addr_is

  assign take = link_rise && req_valid;
  assign ctrl_hit = !req_apndp && addr_is(req_addr, DPSF_CTRL_ADDR)
                    && (req_bank == DPSF_CTRL_BANK);
  assign data_link_control_hit = !req_apndp && addr_is(req_addr, DPSF_CTRL_ADDR)
                    && (req_bank == DPSF_DATA_LINK_CONTROL_BANK);
  assign abort_wr = take && !req_apndp && !req_rnw && addr_is(req_addr, DPSF_ABORT_ADDR);
  assign ctrl_wr = take && !req_rnw && ctrl_hit;
  assign data_link_control_wr = take && !req_rnw && data_link_control_hit;
  assign ap_take = take && req_apndp;

  // ------------------------------------------------------------------
  // Control fields
  // ------------------------------------------------------------------
  logic orun_en_q;
  dpsf_mode_e mode_q;
  logic [3:0] mask_q;
  logic [1:0] turn_q;

  // Overrun enable, mode and lane mask are plain read-write fields
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      orun_en_q <= DPSF_FLAG_RST;
      mode_q <= dpsf_mode_e'(DPSF_MODE_RST);
      mask_q <= DPSF_MASK_RST;
    end else if (ctrl_wr) begin
      orun_en_q <= req_wdata[DPSF_ORUN_EN_BIT];
      mode_q <= dpsf_mode_e'(req_wdata[DPSF_MODE_LSB +: 2]);
      mask_q <= req_wdata[DPSF_MASK_LSB +: 4];
    end
  end

  // Link control holds storage only on the serial wire variant
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      turn_q <= DPSF_TURN_RST;
    end else if (data_link_control_wr && JTAG_VARIANT == 0) begin
      turn_q <= req_wdata[DPSF_TURN_LSB +: 2];
    end
  end

  // ------------------------------------------------------------------
  // Pushed-operation sequencer and port forwarding
  // ------------------------------------------------------------------
  dpsf_state_e st_q;
  logic [31:0] push_data_q;
  logic push_mode;
  logic push_done;
  logic lane_match;
  logic cmp_evt;

  // Reserved mode code behaves as normal operation
  assign push_mode = (mode_q == DPSF_MODE_VERIFY) || (mode_q == DPSF_MODE_COMPARE);
  assign push_done = (st_q == DPSF_ST_PUSH) && ap_resp_valid && ap_resp_read;

  dpsf_lane_cmp #(
    .LANES(4)
  ) u_cmp (
    .a_i(push_data_q),
    .b_i(ap_resp_rdata),
    .mask_i(mask_q),
    .match_o(lane_match)
  );

  // Verify flags a hit, compare flags a miss; errors never compare
  assign cmp_evt = push_done && ap_resp_ok && (HAS_COMPARE == 1)
                   && ((mode_q == DPSF_MODE_VERIFY) ? lane_match : !lane_match);

  // One pushed read is outstanding at a time; new port requests are dropped
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      st_q <= DPSF_ST_IDLE;
      push_data_q <= 32'h0;
    end else begin
      unique case (st_q)
        DPSF_ST_IDLE: begin
          if (ap_take && !req_rnw && push_mode) begin
            st_q <= DPSF_ST_PUSH;
            push_data_q <= req_wdata;
          end
        end
        DPSF_ST_PUSH: begin
          if (push_done) begin
            st_q <= DPSF_ST_IDLE;
          end
        end
        default: begin
          st_q <= DPSF_ST_IDLE;
        end
      endcase
    end
  end

  // Forward port requests; a pushed write goes out as a read
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      ap_req_valid_q <= 1'b0;
      ap_req_rnw_q <= 1'b0;
      ap_req_addr_q <= 4'h0;
      ap_req_wdata_q <= 32'h0;
    end else begin
      ap_req_valid_q <= ap_take && (st_q == DPSF_ST_IDLE);
      if (ap_take && st_q == DPSF_ST_IDLE) begin
        ap_req_rnw_q <= req_rnw || push_mode;
        ap_req_addr_q <= req_addr;
        ap_req_wdata_q <= req_wdata;
      end
    end
  end

  // ------------------------------------------------------------------
  // Sticky flags and read status
  // ------------------------------------------------------------------
  logic err_q;
  logic cmp_q;
  logic orun_q;
  logic rdok_q;
  logic w1c;
  logic err_set;
  logic orun_set;
  logic err_clr;
  logic cmp_clr;
  logic orun_clr;

  assign w1c = ctrl_wr && !RO_FLAGS;
  assign err_set = ap_resp_valid && !ap_resp_ok;
  assign orun_set = overrun_event && orun_en_q;

  // Early scan parts clear everything from the error bit; later ones per flag
  assign err_clr = (w1c && req_wdata[DPSF_ERR_BIT])
                   || (abort_wr && req_wdata[DPSF_ABT_ERRCLR_BIT]);
  assign cmp_clr = (w1c && req_wdata[DPSF_CMP_BIT])
                   || (abort_wr && (RO_FLAGS ? req_wdata[DPSF_ABT_CMPCLR_BIT]
                                             : req_wdata[DPSF_ABT_ERRCLR_BIT]));
  assign orun_clr = (w1c && req_wdata[DPSF_ORUN_BIT])
                    || (abort_wr && (RO_FLAGS ? req_wdata[DPSF_ABT_ORUNCLR_BIT]
                                              : req_wdata[DPSF_ABT_ERRCLR_BIT]));

  // Set wins over clear, so an event in the clearing cycle survives
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      err_q <= DPSF_FLAG_RST;
      cmp_q <= DPSF_FLAG_RST;
      orun_q <= DPSF_FLAG_RST;
    end else begin
      err_q <= (err_q && !err_clr) || err_set;
      cmp_q <= (cmp_q && !cmp_clr) || cmp_evt;
      orun_q <= (orun_q && !orun_clr) || orun_set;
    end
  end

  // On serial wire parts from version 1, read status follows every read answer, good or bad
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      rdok_q <= DPSF_FLAG_RST;
    end else if (HAS_RDOK && ap_resp_valid && ap_resp_read) begin
      rdok_q <= ap_resp_ok;
    end
  end

  // ------------------------------------------------------------------
  // Read answer
  // ------------------------------------------------------------------
  logic [31:0] ctrl_view;
  logic [31:0] data_link_control_view;

  // Unimplemented bits read zero
  always_comb begin
    ctrl_view = 32'h0;
    ctrl_view[DPSF_ORUN_EN_BIT] = orun_en_q;
    ctrl_view[DPSF_ORUN_BIT] = orun_q;
    ctrl_view[DPSF_MODE_LSB +: 2] = mode_q;
    ctrl_view[DPSF_CMP_BIT] = cmp_q;
    ctrl_view[DPSF_ERR_BIT] = err_q;
    ctrl_view[DPSF_RDOK_BIT] = HAS_RDOK ? rdok_q : 1'b0;
    ctrl_view[DPSF_MASK_LSB +: 4] = mask_q;
    data_link_control_view = 32'h0;
    if (JTAG_VARIANT == 0) begin
      data_link_control_view[DPSF_TURN_LSB +: 2] = turn_q;
      data_link_control_view[DPSF_DATA_LINK_CONTROL_ONE_BIT] = 1'b1;
    end
  end

  // Port register reads answer one cycle after the synchronised link edge
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      rdata_q <= 32'h0;
      rdata_valid_q <= 1'b0;
    end else begin
      rdata_valid_q <= take && !req_apndp && req_rnw;
      if (take && !req_apndp && req_rnw) begin
        rdata_q <= ctrl_hit ? ctrl_view : (data_link_control_hit ? data_link_control_view : 32'h0);
      end
    end
  end

  // ------------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------------
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (sys_rst);

  logic rst_seen_q;

  always_ff @(posedge clk) begin
    rst_seen_q <= sys_rst;
  end

  a_err_sets: assert property (err_set |=> err_q)
    else $error("sticky error not set after error answer");
  a_err_holds: assert property (err_q && !err_clr |=> err_q)
    else $error("sticky error dropped without a clear");
  a_clear_set_wins: assert property (orun_set && orun_clr |=> orun_q)
    else $error("overrun set lost to a same-cycle clear");
  a_abort_err_clr: assert property (abort_wr && req_wdata[DPSF_ABT_ERRCLR_BIT]
                                    && !err_set |=> !err_q)
    else $error("abort write did not clear sticky error");
  a_orun_gated: assert property (!orun_en_q && !orun_q |=> !orun_q)
    else $error("overrun flag set while detection disabled");
  a_last_read_ok_flag_track: assert property (HAS_RDOK && ap_resp_valid && ap_resp_read
                                   |=> rdok_q == $past(ap_resp_ok))
    else $error("read ok flag does not follow read answer");
  a_last_read_ok_flag_view: assert property (rdata_valid_q && $past(ctrl_hit)
                                  |-> rdata_q[DPSF_RDOK_BIT] == (HAS_RDOK && $past(rdok_q)))
    else $error("read ok bit wrong in status read");
  a_push_read: assert property (st_q == DPSF_ST_IDLE ##1 st_q == DPSF_ST_PUSH
                                |-> ap_req_valid_q && ap_req_rnw_q)
    else $error("pushed write not issued as a read");
  a_cmp_verify: assert property (cmp_evt |=> cmp_q ##1 (cmp_q || $past(cmp_clr)))
    else $error("compare flag not set by pushed compare event");
  a_reg_answer: assert property (take && !req_apndp && req_rnw |=> rdata_valid_q)
    else $error("port register read not answered next cycle");
  a_orun_sets: assert property (orun_set |=> orun_q)
    else $error("overrun flag not set while detection enabled");
  a_ctrl_write: assert property (ctrl_wr
                                 |=> orun_en_q == $past(req_wdata[DPSF_ORUN_EN_BIT]))
    else $error("overrun enable does not follow control write");

  a_reset_zero: assert property (disable iff (1'b0) rst_seen_q
                                 |-> !err_q && !cmp_q && !orun_q && !orun_en_q
                                 && !rdok_q)
    else $error("flags not zero after powerup reset");

  c_push_compare: cover property (push_done && mode_q == DPSF_MODE_COMPARE ##1 cmp_q);
  c_err_cleared: cover property (err_q ##1 abort_wr ##1 !err_q);
  c_orun_seen: cover property (orun_en_q && overrun_event ##1 orun_q);
  c_verify_hit: cover property (push_done && mode_q == DPSF_MODE_VERIFY ##1 cmp_q);

endmodule : dpsf_status

// ### core/dpsf_pkg.sv
package dpsf_pkg;

  // ------------------------------------------------------------------
  // Port register map
  // ------------------------------------------------------------------
  localparam logic [3:0] DPSF_ABORT_ADDR = 4'h0;  // Write-only abort register
  localparam logic [3:0] DPSF_CTRL_ADDR = 4'h4;   // Control/status and link control share it
  localparam logic [3:0] DPSF_CTRL_BANK = 4'h0;   // Bank that selects port_control_status
  localparam logic [3:0] DPSF_DATA_LINK_CONTROL_BANK = 4'h1;   // Bank that selects data_link_control

  // ------------------------------------------------------------------
  // port_control_status field positions
  // ------------------------------------------------------------------
  localparam int unsigned DPSF_ORUN_EN_BIT = 0;
  localparam int unsigned DPSF_ORUN_BIT = 1;
  localparam int unsigned DPSF_MODE_LSB = 2;
  localparam int unsigned DPSF_CMP_BIT = 4;
  localparam int unsigned DPSF_ERR_BIT = 5;
  localparam int unsigned DPSF_RDOK_BIT = 6;
  localparam int unsigned DPSF_MASK_LSB = 8;

  // ------------------------------------------------------------------
  // Abort register clear bits and link control fields
  // ------------------------------------------------------------------
  localparam int unsigned DPSF_ABT_CMPCLR_BIT = 1;
  localparam int unsigned DPSF_ABT_ERRCLR_BIT = 2;
  localparam int unsigned DPSF_ABT_ORUNCLR_BIT = 4;
  localparam int unsigned DPSF_TURN_LSB = 8;
  localparam int unsigned DPSF_DATA_LINK_CONTROL_ONE_BIT = 6;

  // ------------------------------------------------------------------
  // Reset values
  // ------------------------------------------------------------------
  localparam logic DPSF_FLAG_RST = 1'b0;
  localparam logic [1:0] DPSF_MODE_RST = 2'h0;
  localparam logic [3:0] DPSF_MASK_RST = 4'hf;
  localparam logic [1:0] DPSF_TURN_RST = 2'h0;

  // Transfer modes
  typedef enum logic [1:0] {
    DPSF_MODE_NORMAL = 2'h0,
    DPSF_MODE_VERIFY = 2'h1,
    DPSF_MODE_COMPARE = 2'h2,
    DPSF_MODE_RSVD = 2'h3
  } dpsf_mode_e;

  // Pushed-operation sequencer
  typedef enum logic [1:0] {
    DPSF_ST_IDLE = 2'h0,
    DPSF_ST_PUSH = 2'h1
  } dpsf_state_e;

endpackage : dpsf_pkg

// ### core/dpsf_sync3.sv
`timescale 1ns/100ps

module dpsf_sync3 (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic async_in,
  output logic level_o,
  output logic rise_o
);

  // ------------------------------------------------------------------
  // Three-stage sampler
  // ------------------------------------------------------------------
  logic s1_q;
  logic s2_q;
  logic s3_q;
  logic level_q;

  // Only s2 looks at s1; decisions use s2 and s3 together
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      s1_q <= 1'b0;
      s2_q <= 1'b0;
      s3_q <= 1'b0;
    end else begin
      s1_q <= async_in;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  // A change counts once the last two stages agree
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      level_q <= 1'b0;
    end else if (s2_q == s3_q) begin
      level_q <= s3_q;
    end
  end

  assign level_o = level_q;
  assign rise_o = (s2_q == s3_q) && s3_q && !level_q;

endmodule : dpsf_sync3

// ### core/dpsf_lane_cmp.sv
`timescale 1ns/100ps

module dpsf_lane_cmp #(
  parameter int unsigned LANES = 4
) (
  input wire logic [LANES*8-1:0] a_i,
  input wire logic [LANES*8-1:0] b_i,
  input wire logic [LANES-1:0] mask_i,
  output logic match_o
);

  // ------------------------------------------------------------------
  // Byte-lane comparison
  // ------------------------------------------------------------------
  logic [LANES-1:0] lane_ok;

  // A comparator without lanes would match everything
  if (LANES < 1) begin : g_bad_lanes
    $error("dpsf_lane_cmp: at least one byte lane is needed");
  end

  // A masked-off lane always agrees, so an all-zero mask matches
  for (genvar g = 0; g < LANES; g++) begin : g_lane
    assign lane_ok[g] = !mask_i[g] || (a_i[g*8 +: 8] == b_i[g*8 +: 8]);
  end

  assign match_o = &lane_ok;

endmodule : dpsf_lane_cmp

// ### testbench/dpsf_probe.sv
`timescale 1ns/100ps

// ------------------------------------------------------------------
// Debugger probe: one request per link clock period
// ------------------------------------------------------------------
module dpsf_probe (
  input wire logic clk,
  output logic link_clk,
  output logic req_valid,
  output logic req_apndp,
  output logic req_rnw,
  output logic [3:0] req_addr,
  output logic [3:0] req_bank,
  output logic [31:0] req_wdata
);
  // Link clock stands low between frames
  initial begin
    link_clk = 1'b0;
    req_valid = 1'b0;
    req_apndp = 1'b0;
    req_rnw = 1'b0;
    req_addr = 4'h0;
    req_bank = 4'h0;
    req_wdata = 32'h0;
  end

  // Fields stay put well past the take edge, then turn to junk so
  // that a design latching late sees the wrong value
  task automatic xfer(input logic apndp, input logic rnw, input logic [3:0] addr,
                      input logic [3:0] bank, input logic [31:0] wdata);
    @(posedge clk);
    req_valid <= 1'b1;
    req_apndp <= apndp;
    req_rnw <= rnw;
    req_addr <= {addr[3:2], 2'b00};
    req_bank <= bank;
    req_wdata <= wdata;
    // One link clock period of eight system clocks, high for the first half
    @(posedge clk);
    link_clk <= 1'b1;
    repeat (4) @(posedge clk);
    link_clk <= 1'b0;
    repeat (4) @(posedge clk);
    req_valid <= 1'b0;
    req_apndp <= ~apndp;
    req_rnw <= ~rnw;
    req_addr <= ~addr;
    req_bank <= ~bank;
    req_wdata <= ~wdata;
  endtask : xfer
endmodule : dpsf_probe

// ### testbench/debug_port_status_flags_test.sv
`timescale 1ns/100ps

module debug_port_status_flags_test
  import dpsf_pkg::*;
();
  logic clk, sys_rst, link_clk, req_valid, req_apndp, req_rnw;
  logic [3:0] req_addr, req_bank, ap_req_addr_q, ap_addr;
  logic [31:0] req_wdata, ap_resp_rdata, rdata_q, ap_req_wdata_q, ap_wd, rd_got, d, r;
  logic ap_resp_valid, ap_resp_ok, ap_resp_read, overrun_event;
  logic rdata_valid_q, ap_req_valid_q, ap_req_rnw_q, ap_rnw, rd_seen;
  int bad_count, n_checks, ap_cnt, n, m, c;
  int m_en, m_orun, m_mode, m_cmp, m_err, m_rdok, m_mask;

  // ------------------------------------------------------------------
  // Clock, design and probe
  // ------------------------------------------------------------------
  initial clk = 1'b0;
  always #12.5 clk = ~clk;

  dpsf_status dut_u (.clk(clk), .sys_rst(sys_rst), .link_clk(link_clk),
    .req_valid(req_valid), .req_apndp(req_apndp), .req_rnw(req_rnw),
    .req_addr(req_addr), .req_bank(req_bank), .req_wdata(req_wdata),
    .ap_resp_valid(ap_resp_valid), .ap_resp_ok(ap_resp_ok), .ap_resp_read(ap_resp_read),
    .ap_resp_rdata(ap_resp_rdata), .overrun_event(overrun_event), .rdata_q(rdata_q),
    .rdata_valid_q(rdata_valid_q), .ap_req_valid_q(ap_req_valid_q),
    .ap_req_rnw_q(ap_req_rnw_q), .ap_req_addr_q(ap_req_addr_q),
    .ap_req_wdata_q(ap_req_wdata_q));

  dpsf_probe probe_u (.clk(clk), .link_clk(link_clk), .req_valid(req_valid),
    .req_apndp(req_apndp), .req_rnw(req_rnw), .req_addr(req_addr),
    .req_bank(req_bank), .req_wdata(req_wdata));

  // One-cycle pulses are caught in the cycle they stand
  always @(posedge clk) begin
    if (rdata_valid_q === 1'b1) begin
      rd_seen <= 1'b1;
      rd_got <= rdata_q;
    end
    if (ap_req_valid_q === 1'b1) begin
      ap_cnt <= ap_cnt + 1;
      ap_rnw <= ap_req_rnw_q;
      ap_addr <= ap_req_addr_q;
      ap_wd <= ap_req_wdata_q;
    end
  end

  // ------------------------------------------------------------------
  // Checking and model helpers
  // ------------------------------------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task automatic give_verdict();
    $display("checks=%0d mismatches=%0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : give_verdict

  function automatic logic [31:0] exp_stat();
    return 32'(m_mask << DPSF_MASK_LSB | m_rdok << DPSF_RDOK_BIT | m_err << DPSF_ERR_BIT
      | m_cmp << DPSF_CMP_BIT | m_mode << DPSF_MODE_LSB | m_orun << DPSF_ORUN_BIT | m_en);
  endfunction : exp_stat

  // Mask bit zero drops the lane; an all-zero mask always matches
  function automatic int lanes_match(input logic [31:0] a, input logic [31:0] b, input int k);
    for (int i = 0; i < 4; i++) begin
      if (k[i] && a[8*i+:8] != b[8*i+:8]) return 0;
    end
    return 1;
  endfunction : lanes_match

  task automatic do_reset();
    sys_rst <= 1'b1;
    repeat (10) @(posedge clk);
    sys_rst <= 1'b0;
    repeat (4) @(posedge clk);
    m_en = 0;
    m_orun = 0;
    m_mode = 0;
    m_cmp = 0;
    m_err = 0;
    m_rdok = 0;
    m_mask = 15;
  endtask : do_reset

  task automatic rd(input logic [3:0] addr, input logic [3:0] bank, input logic [31:0] exp);
    rd_seen = 1'b0;
    probe_u.xfer(1'b0, 1'b1, addr, bank, $urandom);
    check(32'(rd_seen), 32'h1);
    check(rd_got, exp);
  endtask : rd

  // Flag positions are written as ones; they must not move
  task automatic wr_ctrl(input int en, input int mode, input int mask);
    probe_u.xfer(1'b0, 1'b0, 4'h4, 4'h0,
      32'h72 | 32'(mask << DPSF_MASK_LSB | mode << DPSF_MODE_LSB | en));
    m_en = en;
    m_mode = mode; // Nonzero only outside the minimal configuration
    m_mask = mask;
  endtask : wr_ctrl

  task automatic ap_ans(input logic ok, input logic rdn, input logic [31:0] data);
    @(posedge clk);
    ap_resp_valid <= 1'b1;
    ap_resp_ok <= ok;
    ap_resp_read <= rdn;
    ap_resp_rdata <= data;
    @(posedge clk);
    ap_resp_valid <= 1'b0;
    ap_resp_ok <= ~ok;
    ap_resp_rdata <= ~data;
    if (rdn) m_rdok = ok;
    if (!ok) m_err = 1;
  endtask : ap_ans

  task automatic orun_pulse();
    @(posedge clk);
    overrun_event <= 1'b1;
    @(posedge clk);
    overrun_event <= 1'b0;
    if (m_en != 0) m_orun = 1;
  endtask : orun_pulse

  task automatic abort(input logic [31:0] bits);
    probe_u.xfer(1'b0, 1'b0, 4'h0, 4'($urandom), bits);
    if (bits[DPSF_ABT_CMPCLR_BIT]) m_cmp = 0;
    if (bits[DPSF_ABT_ERRCLR_BIT]) m_err = 0;
    if (bits[DPSF_ABT_ORUNCLR_BIT]) m_orun = 0;
  endtask : abort

  // ------------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------------
  initial begin
    sys_rst = 1'b1;
    ap_resp_valid = 1'b0;
    ap_resp_ok = 1'b0;
    ap_resp_read = 1'b0;
    ap_resp_rdata = 32'h0;
    overrun_event = 1'b0;
    rd_seen = 1'b0;
    void'($urandom(32'h4692));
    do_reset();
    rd(4'h4, 4'h0, exp_stat());
    rd(4'h4, 4'h1, 32'h40);
    rd(4'h0, 4'h0, 32'h0);
    rd(4'h8, 4'h0, 32'h0);
    d = $urandom;
    probe_u.xfer(1'b0, 1'b0, 4'h4, 4'h1, d);
    rd(4'h4, 4'h1, 32'h40 | 32'(d[9:8]) << DPSF_TURN_LSB);
    wr_ctrl(0, 0, 15);
    rd(4'h4, 4'h0, exp_stat());
    // Normal mode passes writes and reads straight through
    d = $urandom;
    n = ap_cnt;
    probe_u.xfer(1'b1, 1'b0, 4'hc, 4'h0, d);
    check(32'(ap_cnt - n), 32'h1);
    check({27'h0, ap_rnw, ap_addr}, 32'hc);
    check(ap_wd, d);
    probe_u.xfer(1'b1, 1'b1, 4'h8, 4'h0, $urandom);
    check(32'(ap_rnw), 32'h1);
    ap_ans(1'b0, 1'b1, $urandom);
    rd(4'h4, 4'h0, exp_stat());
    probe_u.xfer(1'b1, 1'b1, 4'h8, 4'h0, $urandom);
    ap_ans(1'b1, 1'b1, $urandom);
    rd(4'h4, 4'h0, exp_stat());
    orun_pulse();
    rd(4'h4, 4'h0, exp_stat());
    wr_ctrl(1, 0, 15);
    orun_pulse();
    rd(4'h4, 4'h0, exp_stat());
    abort(32'h4);
    rd(4'h4, 4'h0, exp_stat());
    // Pushed writes become reads; match or mismatch per mode and lane mask
    for (int i = 0; i < 6; i++) begin
      m = 1 + i / 3;
      c = i % 3;
      wr_ctrl(1, m, (c == 2) ? 1 : 15);
      d = $urandom;
      n = ap_cnt;
      probe_u.xfer(1'b1, 1'b0, 4'h4, 4'h0, d);
      check(32'(ap_cnt - n), 32'h1);
      check(32'(ap_rnw), 32'h1);
      r = (c == 0) ? d : d ^ 32'hff00_0000;
      ap_ans(1'b1, 1'b1, r);
      if ((lanes_match(d, r, m_mask) != 0) == (m == 1)) m_cmp = 1;
      rd(4'h4, 4'h0, exp_stat());
      abort(32'h2);
      rd(4'h4, 4'h0, exp_stat());
    end
    // Reserved mode code forwards writes as plain writes
    wr_ctrl(1, 3, 15);
    d = $urandom;
    n = ap_cnt;
    probe_u.xfer(1'b1, 1'b0, 4'h4, 4'h0, d);
    check(32'(ap_cnt - n), 32'h1);
    check({27'h0, ap_rnw, ap_addr}, 32'h4);
    check(ap_wd, d);
    rd(4'h4, 4'h0, exp_stat());
    wr_ctrl(1, 0, 15);
    probe_u.xfer(1'b1, 1'b1, 4'h8, 4'h0, $urandom);
    ap_ans(1'b0, 1'b1, $urandom);
    orun_pulse();
    abort(32'h16);
    rd(4'h4, 4'h0, exp_stat());
    // Replay the failed read once the overrun flag is clear
    n = ap_cnt;
    probe_u.xfer(1'b1, 1'b1, 4'h8, 4'h0, $urandom);
    check(32'(ap_cnt - n), 32'h1);
    check({27'h0, ap_rnw, ap_addr}, 32'h18);
    do_reset();
    rd(4'h4, 4'h0, exp_stat());
    give_verdict();
  end

  // Whole run needs about 16 us; over twelve times that means a hang
  initial begin
    #200000;
    bad_count++;
    give_verdict();
  end
endmodule : debug_port_status_flags_test
